// ### hdl/bfe_alu.sv
// Single-cycle bit, shift, flag and move operations
`timescale 1ns/10ps
`default_nettype none
module bfe_alu
    import bfe_pkg::*;
(
    // Command and operands
    input  wire bfe_cmd_t   cmd,
    input  wire logic [7:0] dst_val,
    input  wire logic [7:0] src_val,
    input  wire logic [7:0] imm,
    input  wire logic [7:0] flags_in,
    // Result
    output bfe_alu_t        alu
);

    always_comb begin
        logic [7:0] r;
        r         = dst_val;
        alu.res   = dst_val;
        alu.wr    = 1'b0;
        alu.flags = flags_in;
        case (cmd.op)
            OP_RRC, OP_SRA: begin
                if (cmd.op == OP_RRC) begin
                    r = {flags_in[FC], dst_val[7:1]};
                end else begin
                    r = {dst_val[7], dst_val[7:1]};
                end
                alu.res       = r;
                alu.wr        = 1'b1;
                alu.flags[FC] = dst_val[0];
                alu.flags[FZ] = (r == 8'h00);
                alu.flags[FN] = r[7];
                alu.flags[FV] = r[7] ^ dst_val[0];
            end
            OP_SWAP: begin
                alu.res = {dst_val[3:0], dst_val[7:4]};
                alu.wr  = 1'b1;
            end
            OP_BTT: alu.flags[FT] = src_val[cmd.bsel];
            OP_TTB: begin
                alu.res[cmd.bsel] = flags_in[FT];
                alu.wr            = 1'b1;
            end
            OP_FSET: alu.flags[cmd.bsel] = 1'b1;
            OP_FCLR: alu.flags[cmd.bsel] = 1'b0;
            OP_CPY: begin
                alu.res = src_val;
                alu.wr  = 1'b1;
            end
            OP_LDI: begin
                alu.res = imm;
                alu.wr  = 1'b1;
            end
            default: alu.wr = 1'b0;
        endcase
    end

endmodule : bfe_alu
`default_nettype wire

// ### hdl/bfe_exec_top.sv
// Execution unit with register file, flag word and data memory behind AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module bfe_exec_top
    import bfe_pkg::*;
#(
    parameter int MEM_DEPTH = 256
)(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Status
    output logic             busy
);

    localparam int AW = $clog2(MEM_DEPTH);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_MEM  = 3'b100
    } bfe_st_t;

    typedef enum logic [2:0] {
        RG_CMD, RG_OPND, RG_STAT, RG_FLAG, RG_GPR, RG_MEM, RG_NONE
    } bfe_rg_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic bfe_rg_t region(input logic [11:0] a);
        if (a[1:0] != 2'h0) begin
            region = RG_NONE;
        end else if (a == OFS_CMD) begin
            region = RG_CMD;
        end else if (a == OFS_OPND) begin
            region = RG_OPND;
        end else if (a == OFS_STAT) begin
            region = RG_STAT;
        end else if (a == OFS_FLAG) begin
            region = RG_FLAG;
        end else if (a >= OFS_GPR && a < OFS_GPR + GPR_SPAN) begin
            region = RG_GPR;
        end else if (a >= OFS_MEM && a < OFS_MEM + 12'(4 * MEM_DEPTH)) begin
            region = RG_MEM;
        end else begin
            region = RG_NONE;
        end
    endfunction : region

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge

    function automatic logic [4:0] ptr_lo(input logic [1:0] p);
        ptr_lo = PTR_X_LO + {2'h0, p, 1'b0};
    endfunction : ptr_lo

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bfe_st_t        st_ff;
    bfe_st_t        nxt_st;
    bfe_cmd_t       cmd_ff;
    logic [15:0]    opnd_ff;
    logic [7:0]     flags_ff;
    logic [7:0]     gpr_ff [32];
    logic [7:0]     mem_ff [MEM_DEPTH];
    logic [15:0]    addr_ff;
    logic [15:0]    nxt_addr;
    logic [3:0]     cyc_ff;
    logic [3:0]     last_cyc_ff;
    logic           awready_ff;
    logic           wready_ff;
    logic           bvalid_ff;
    logic [1:0]     bresp_ff;
    logic           arready_ff;
    logic           rvalid_ff;
    logic [31:0]    rdata_ff;
    logic [1:0]     rresp_ff;
    logic           busy_ff;
    logic           wr_fire;
    logic           wr_ok;
    logic           start;
    bfe_rg_t        wrg;
    bfe_rg_t        rrg;
    logic [31:0]    rd_word;
    logic [4:0]     plo;
    logic [15:0]    ptr_val;
    logic           is_mem;
    logic           is_load;
    logic           is_ind;
    logic [AW-1:0]  midx;
    logic [31:0]    cmd_word;
    bfe_alu_t       alu;

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign busy          = busy_ff;

    assign plo      = ptr_lo(cmd_ff.ptr);
    assign ptr_val  = {gpr_ff[plo + 5'h01], gpr_ff[plo]};
    assign is_load  = (cmd_ff.op == OP_RI) || (cmd_ff.op == OP_RDD) || (cmd_ff.op == OP_RDS);
    assign is_mem   = is_load || (cmd_ff.op == OP_WI) || (cmd_ff.op == OP_WDD)
                      || (cmd_ff.op == OP_WDS);
    assign is_ind   = (cmd_ff.op == OP_RI) || (cmd_ff.op == OP_WI);
    assign midx     = addr_ff[AW-1:0];
    assign cmd_word = {10'h000, cmd_ff};

    bfe_alu u_alu (
        .cmd      (cmd_ff),
        .dst_val  (gpr_ff[cmd_ff.rd]),
        .src_val  (gpr_ff[cmd_ff.rr]),
        .imm      (opnd_ff[7:0]),
        .flags_in (flags_ff),
        .alu      (alu)
    );

    // ------------------------------------------------------------
    // Bus write channel
    // ------------------------------------------------------------
    assign wr_fire = awready_ff && s_axi_awvalid && wready_ff && s_axi_wvalid;
    assign wrg     = region(s_axi_awaddr);
    assign wr_ok   = (wrg != RG_NONE) && (wrg != RG_STAT) && !busy_ff;
    assign start   = wr_fire && wr_ok && (wrg == RG_CMD) && (s_axi_wstrb != 4'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
        end else begin
            awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
            wready_ff  <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_ok ? RESP_OKAY : RESP_ERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus read channel
    // ------------------------------------------------------------
    assign rrg = region(s_axi_araddr);

    always_comb begin
        rd_word = 32'h0000_0000;
        if (rrg == RG_CMD) begin
            rd_word = cmd_word;
        end else if (rrg == RG_OPND) begin
            rd_word = {16'h0000, opnd_ff};
        end else if (rrg == RG_STAT) begin
            rd_word[STAT_BUSY]           = busy_ff;
            rd_word[STAT_CYC +: 4]       = last_cyc_ff;
        end else if (rrg == RG_FLAG) begin
            rd_word = {24'h000000, flags_ff};
        end else if (rrg == RG_GPR) begin
            rd_word = {24'h000000, gpr_ff[s_axi_araddr[6:2]]};
        end else if (rrg == RG_MEM) begin
            rd_word = {24'h000000, mem_ff[s_axi_araddr[AW+1:2]]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else begin
            arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
            if (arready_ff && s_axi_arvalid) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_word;
                rresp_ff  <= (rrg == RG_NONE) ? RESP_ERR : RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Command and operand registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_ff  <= bfe_cmd_t'(22'h000000);
            opnd_ff <= 16'h0000;
        end else if (wr_fire && wr_ok) begin
            if (wrg == RG_CMD) begin
                cmd_ff <= bfe_cmd_t'(22'(merge(cmd_word, s_axi_wdata, s_axi_wstrb)));
            end else if (wrg == RG_OPND) begin
                opnd_ff <= 16'(merge({16'h0000, opnd_ff}, s_axi_wdata, s_axi_wstrb));
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: nxt_st = start ? ST_EXEC : ST_IDLE;
            ST_EXEC: nxt_st = is_mem ? ST_MEM : ST_IDLE;
            ST_MEM:  nxt_st = ST_IDLE;
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff   <= ST_IDLE;
            busy_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            busy_ff <= (nxt_st != ST_IDLE);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_ff      <= 4'h0;
            last_cyc_ff <= 4'h0;
        end else if (st_ff == ST_IDLE) begin
            cyc_ff <= 4'h0;
        end else begin
            cyc_ff <= cyc_ff + 4'h1;
            if (nxt_st == ST_IDLE) begin
                last_cyc_ff <= cyc_ff + 4'h1;
            end
        end
    end

    // Effective address formed in the first cycle of a memory access
    always_comb begin
        nxt_addr = ptr_val;
        if (cmd_ff.op == OP_RDS || cmd_ff.op == OP_WDS) begin
            nxt_addr = opnd_ff;
        end else if (cmd_ff.op == OP_RDD || cmd_ff.op == OP_WDD) begin
            nxt_addr = ptr_val + {10'h000, opnd_ff[DISP_W-1:0]};
        end else if (cmd_ff.mode == MODE_PREDEC) begin
            nxt_addr = ptr_val - 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_ff <= 16'h0000;
        end else if (st_ff == ST_EXEC) begin
            addr_ff <= nxt_addr;
        end
    end

    // ------------------------------------------------------------
    // Flag word
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff <= FLAG_RST;
        end else if (st_ff == ST_EXEC) begin
            flags_ff <= alu.flags;
        end else if (wr_fire && wr_ok && wrg == RG_FLAG && s_axi_wstrb[0]) begin
            flags_ff <= s_axi_wdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 32; i++) begin
                gpr_ff[i] <= 8'h00;
            end
        end else begin
            if (wr_fire && wr_ok && wrg == RG_GPR && s_axi_wstrb[0]) begin
                gpr_ff[s_axi_awaddr[6:2]] <= s_axi_wdata[7:0];
            end
            if (st_ff == ST_EXEC) begin
                if (alu.wr) begin
                    gpr_ff[cmd_ff.rd] <= alu.res;
                end
                if (cmd_ff.op == OP_CPYW) begin
                    gpr_ff[{cmd_ff.rd[4:1], 1'b0}] <= gpr_ff[{cmd_ff.rr[4:1], 1'b0}];
                    gpr_ff[{cmd_ff.rd[4:1], 1'b1}] <= gpr_ff[{cmd_ff.rr[4:1], 1'b1}];
                end
                if (is_ind && cmd_ff.mode == MODE_PREDEC) begin
                    gpr_ff[plo]         <= nxt_addr[7:0];
                    gpr_ff[plo + 5'h01] <= nxt_addr[15:8];
                end
            end
            if (st_ff == ST_MEM) begin
                if (is_ind && cmd_ff.mode == MODE_POSTINC) begin
                    gpr_ff[plo]         <= 8'(addr_ff + 16'h0001);
                    gpr_ff[plo + 5'h01] <= 8'((addr_ff + 16'h0001) >> 8);
                end
                if (is_load) begin
                    gpr_ff[cmd_ff.rd] <= mem_ff[midx];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (st_ff == ST_MEM && !is_load) begin
            mem_ff[midx] <= gpr_ff[cmd_ff.rr];
        end else if (wr_fire && wr_ok && wrg == RG_MEM && s_axi_wstrb[0]) begin
            mem_ff[s_axi_awaddr[AW+1:2]] <= s_axi_wdata[7:0];
        end
    end

endmodule : bfe_exec_top
`default_nettype wire

// ### hdl/bfe_pkg.sv
// Constants, types and register map of the bit, flag and load/store execution unit
// Operation
// - Rotate right through carry: old C into bit 7, bit 0 to C; Z,C,N,V; one cycle.
// - Flag capture copies selected source bit into T only, one cycle.
// - Bit from flag writes T into selected destination bit, no flags, one cycle.
// - Overflow flag V is set or cleared alone, one cycle.
// - Half-carry flag H is set or cleared alone, one cycle.
// - Signed flag S is set or cleared alone, one cycle.
// - Indirect read with post-increment reads at pointer then adds one; two cycles.
// - Indirect read with pre-decrement subtracts one first, then reads; two cycles.
// - Displaced read uses the pointer selected by ptr (X, Y or Z) plus unsigned offset, pointer kept; two cycles.
// - Direct read uses address from the instruction; two cycles, no flags.
// - Indirect write with post-increment stores then adds one to pointer; two cycles.
// - Indirect write with pre-decrement subtracts one then stores; two cycles.
package bfe_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CMD   = 12'h000;
    localparam logic [11:0] OFS_OPND  = 12'h004;
    localparam logic [11:0] OFS_STAT  = 12'h008;
    localparam logic [11:0] OFS_FLAG  = 12'h00c;
    localparam logic [11:0] OFS_GPR   = 12'h100;
    localparam logic [11:0] GPR_SPAN  = 12'h080;
    localparam logic [11:0] OFS_MEM   = 12'h400;
    localparam logic [11:0] MEM_SPAN  = 12'h400;
    localparam int          STAT_BUSY = 0;
    localparam int          STAT_CYC  = 4;
    localparam logic [7:0]  FLAG_RST  = 8'h00;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;

    // ------------------------------------------------------------
    // Flag word bit positions
    // ------------------------------------------------------------
    localparam int FC = 0;
    localparam int FZ = 1;
    localparam int FN = 2;
    localparam int FV = 3;
    localparam int FS = 4;
    localparam int FH = 5;
    localparam int FT = 6;
    localparam int FI = 7;

    // ------------------------------------------------------------
    // Pointers and addressing modes
    // ------------------------------------------------------------
    localparam logic [4:0] PTR_X_LO     = 5'h1a;
    localparam logic [1:0] MODE_PLAIN   = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_PREDEC  = 2'h2;
    localparam int         DISP_W       = 6;

    typedef enum logic [4:0] {
        OP_RRC  = 5'h00, OP_SRA  = 5'h01, OP_SWAP = 5'h02, OP_BTT  = 5'h03,
        OP_TTB  = 5'h04, OP_FSET = 5'h05, OP_FCLR = 5'h06, OP_CPY  = 5'h07,
        OP_CPYW = 5'h08, OP_LDI  = 5'h09, OP_RI   = 5'h0a, OP_RDD  = 5'h0b,
        OP_RDS  = 5'h0c, OP_WI   = 5'h0d, OP_WDD  = 5'h0e, OP_WDS  = 5'h0f
    } bfe_op_t;

    // Command word, low bits of the command register
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] ptr;
        logic [2:0] bsel;
        logic [4:0] rr;
        logic [4:0] rd;
        bfe_op_t    op;
    } bfe_cmd_t;

    typedef struct packed {
        logic [7:0] res;
        logic       wr;
        logic [7:0] flags;
    } bfe_alu_t;

endpackage : bfe_pkg

// ### verif/bfe_axi_master.sv
// Register bus master standing in for software
`timescale 1ns/10ps
`default_nettype none
module bfe_axi_master
    import bfe_pkg::*;
(
    // Clock
    input  wire logic        aclk,
    // Write
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            if (s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    // Slow reader: rready two cycles late to exercise held data
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat (2) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : bfe_axi_master
`default_nettype wire

// ### verif/bfe_exec_top_chk.sv
// Bus and busy timing checker of the execution unit
`timescale 1ns/10ps
`default_nettype none
module bfe_exec_top_chk
    import bfe_pkg::*;
#(
    parameter int MEM_DEPTH = 256
)(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Status
    input wire logic        busy
);
    logic wr_hs;
    logic start;
    logic mem_op;
    assign wr_hs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign start  = wr_hs && s_axi_awaddr == OFS_CMD && !busy;
    assign mem_op = s_axi_wdata[4:0] inside {[5'h0a:5'h0f]};
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_ONE_CYCLE:
        assert property (start && !mem_op |=> busy ##1 !busy) else $error("short op span");
    AST_TWO_CYCLE:
        assert property (start && mem_op |=> busy[*2] ##1 !busy) else $error("memory op span");
    AST_BUSY_CAUSE:
        assert property ($rose(busy) |-> $past(start)) else $error("busy without command");
    AST_READY_PAIR:
        assert property (s_axi_awready |-> s_axi_wready && $past(s_axi_awvalid && s_axi_wvalid))
            else $error("write readies apart");
    AST_READY_PULSE:
        assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
    AST_BRESP:
        assert property (wr_hs |=> s_axi_bvalid) else $error("write response late");
    AST_RVALID:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    AST_RHOLD:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
            else $error("read data not held");
endmodule : bfe_exec_top_chk
`default_nettype wire

// ### verif/bfe_exec_top_tb.sv
// Self-checking testbench of the execution unit
`timescale 1ns/10ps
`default_nettype none
module bfe_exec_top_tb
    import bfe_pkg::*;
;
    logic        aclk, aresetn, busy, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          fails, n_compared;

    bfe_exec_top #(.MEM_DEPTH(256)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy);
    bfe_axi_master bus (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial aclk = 1'b0;
    always #10 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        bus.wr(a, d, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        bus.rd(a, d, r);
        chk("rresp", {30'h0, er}, {30'h0, r});
        chk("rdata", ed, d);
    endtask : rd
    // Register file byte n
    task automatic wg(input int n, input logic [7:0] v);
        wr(OFS_GPR + 12'(4 * n), {24'h0, v}, RESP_OKAY);
    endtask : wg
    task automatic cg(input int n, input logic [7:0] v);
        rd(OFS_GPR + 12'(4 * n), {24'h0, v}, RESP_OKAY);
    endtask : cg
    task automatic cf(input logic [7:0] v);
        rd(OFS_FLAG, {24'h0, v}, RESP_OKAY);
    endtask : cf
    // Issue one command and check the cycle count it reports
    task automatic ex(input bfe_op_t op, input logic [4:0] d, s, input logic [2:0] b,
                      input logic [1:0] p, m, input logic [15:0] k, input logic [3:0] nc);
        wr(OFS_OPND, {16'h0, k}, RESP_OKAY);
        wr(OFS_CMD, {10'h0, m, p, b, s, d, op}, RESP_OKAY);
        rd(OFS_STAT, {24'h0, nc, 4'h0}, RESP_OKAY);
    endtask : ex
    task automatic conclude();
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        conclude();
    end

    initial begin
        int         fx[3];
        logic [7:0] fm;
        fx = '{FV, FH, FS};
        fails = 0;
        n_compared = 0;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        cf(FLAG_RST);
        cg(5, 8'h00);
        rd(12'h010, 32'h0, RESP_ERR);
        wr(OFS_STAT, 32'h0, RESP_ERR);
        wg(1, 8'h81);
        wr(OFS_FLAG, 32'h01, RESP_OKAY);
        ex(OP_RRC, 5'd1, 5'd0, 3'd0, 2'd0, MODE_PLAIN, 16'h0, 4'h1);
        cg(1, 8'hc0);
        cf(8'h05);
        wg(2, 8'h85);
        wr(OFS_FLAG, 32'h10, RESP_OKAY);
        ex(OP_SRA, 5'd2, 5'd0, 3'd0, 2'd0, MODE_PLAIN, 16'h0, 4'h1);
        cg(2, 8'hc2);
        wg(3, 8'h3c);
        ex(OP_SWAP, 5'd3, 5'd0, 3'd0, 2'd0, MODE_PLAIN, 16'h0, 4'h1);
        cg(3, 8'hc3);
        cf(8'h15);
        wg(4, 8'h10);
        ex(OP_BTT, 5'd0, 5'd4, 3'd4, 2'd0, MODE_PLAIN, 16'h0, 4'h1);
        cf(8'h55);
        wg(5, 8'h01);
        ex(OP_TTB, 5'd5, 5'd0, 3'd7, 2'd0, MODE_PLAIN, 16'h0, 4'h1);
        cg(5, 8'h81);
        cf(8'h55);
        foreach (fx[j]) begin
            fm = 8'h01 << fx[j];
            wr(OFS_FLAG, {24'h0, 8'h55 & ~fm}, RESP_OKAY);
            ex(OP_FSET, 5'd0, 5'd0, 3'(fx[j]), 2'd0, MODE_PLAIN, 16'h0, 4'h1);
            cf(8'h55 | fm);
            ex(OP_FCLR, 5'd0, 5'd0, 3'(fx[j]), 2'd0, MODE_PLAIN, 16'h0, 4'h1);
            cf(8'h55 & ~fm);
        end
        ex(OP_CPY, 5'd6, 5'd1, 3'd0, 2'd0, MODE_PLAIN, 16'h0, 4'h1);
        ex(OP_CPYW, 5'd8, 5'd2, 3'd0, 2'd0, MODE_PLAIN, 16'h0, 4'h1);
        ex(OP_LDI, 5'd10, 5'd0, 3'd0, 2'd0, MODE_PLAIN, 16'h00a5, 4'h1);
        cg(6, 8'hc0);
        cg(8, 8'hc2);
        cg(9, 8'hc3);
        cg(10, 8'ha5);
        ex(OP_WDS, 5'd0, 5'd10, 3'd0, 2'd0, MODE_PLAIN, 16'h0020, 4'h2);
        rd(OFS_MEM + 12'h080, 32'ha5, RESP_OKAY);
        ex(OP_RDS, 5'd11, 5'd0, 3'd0, 2'd0, MODE_PLAIN, 16'h0020, 4'h2);
        cg(11, 8'ha5);
        wg(26, 8'h30);
        wg(27, 8'h00);
        ex(OP_WI, 5'd0, 5'd1, 3'd0, 2'd0, MODE_POSTINC, 16'h0, 4'h2);
        rd(OFS_MEM + 12'h0c0, 32'hc0, RESP_OKAY);
        cg(26, 8'h31);
        ex(OP_RI, 5'd12, 5'd0, 3'd0, 2'd0, MODE_PREDEC, 16'h0, 4'h2);
        cg(26, 8'h30);
        cg(12, 8'hc0);
        wg(28, 8'h30);
        wg(29, 8'h00);
        ex(OP_RI, 5'd13, 5'd0, 3'd0, 2'd1, MODE_POSTINC, 16'h0, 4'h2);
        cg(13, 8'hc0);
        cg(28, 8'h31);
        wg(30, 8'h41);
        wg(31, 8'h00);
        ex(OP_WI, 5'd0, 5'd2, 3'd0, 2'd2, MODE_PREDEC, 16'h0, 4'h2);
        cg(30, 8'h40);
        rd(OFS_MEM + 12'h100, 32'hc2, RESP_OKAY);
        ex(OP_RDD, 5'd14, 5'd0, 3'd0, 2'd1, MODE_PLAIN, 16'h000f, 4'h2);
        cg(14, 8'hc2);
        cg(28, 8'h31);
        cf(8'h45);
        conclude();
    end
endmodule : bfe_exec_top_tb

bind bfe_exec_top bfe_exec_top_chk #(.MEM_DEPTH(MEM_DEPTH)) u_chk (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .busy);
`default_nettype wire
